// File: common/mscb_regs.vh
/*
  register offsets, field positions, reset values and timing counts
  for the misc system csr block. assumes byte offsets on a 16-bit
  host bus where address bit 1 picks the halfword.
*/
`ifndef MSCB_REGS_VH
`define MSCB_REGS_VH

// byte offsets of the 32-bit registers
`define MSCB_OFF_PINCFG   8'h88
`define MSCB_OFF_TMRCFG   8'h8C
`define MSCB_OFF_TMRCNT   8'h90
`define MSCB_OFF_HWORD    8'h98
`define MSCB_OFF_TICK     8'h9C
`define MSCB_OFF_DROP     8'hA0
`define MSCB_OFF_MACCMD   8'hA4
`define MSCB_OFF_MACDAT   8'hA8

// pin function field, bits 22:20 (high halfword bits 6:4)
`define MSCB_PINFN_LSB    4
`define MSCB_PINFN_MSB    6
// general output data, bits 4:3
`define MSCB_GENERAL_OUTPUT_THREE_BIT     3
`define MSCB_GENERAL_OUTPUT_FOUR_BIT     4

// pin function codes
`define MSCB_FN_EEPROM    3'h0
`define MSCB_FN_GPO_GPO   3'h1
`define MSCB_FN_GPO_RXDV  3'h3
`define MSCB_FN_TXEN_GPO  3'h5
`define MSCB_FN_TXEN_RXDV 3'h6
`define MSCB_FN_CLKS      3'h7

// timer run bit 29 (high halfword bit 13)
`define MSCB_TMR_RUN_BIT  13
`define MSCB_TMR_RST      16'hFFFF

// indirect command, high halfword bits 15 and 14
`define MSCB_CMD_PEND_BIT 15
`define MSCB_CMD_RNW_BIT  14

`define MSCB_SWAP_KEY     32'hFFFFFFFF

// timing: host clock and free-running counter rate
`define MSCB_CLK_MHZ      250
`define MSCB_TICK_MHZ     25
`define MSCB_TICK_DIV     (`MSCB_CLK_MHZ / `MSCB_TICK_MHZ)
// timer step period in microseconds
`define MSCB_TMR_STEP_US  100
`define MSCB_TMR_STEP_CYC (`MSCB_TMR_STEP_US * `MSCB_CLK_MHZ)

`endif

// File: hw/mscb_csr_block.v
/*
  misc system csr block: pin function select, general-purpose timer,
  halfword order, free-running 25 MHz counter, dropped-frame counter
  and the indirect port into the mac register space.
  assumes a synchronous 16-bit host port with one-cycle read/write
  strobes, and a mac register side that answers with a one-cycle ack.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mscb_regs.vh"

// Contract
// RULE_01 - pin function code routes the two eeprom pins; 010 and 100 reserved
// RULE_02 - writing one to run bit starts timer, clearing halts it
// RULE_03 - run bit falling forces preload field to all ones
// RULE_04 - 16-bit preload supplies timer load value, resets to all ones
// RULE_05 - timer raises interrupt events at configured intervals
// RULE_06 - read-only count field shows present timer value, resets all ones
// RULE_07 - normal order: A[1] high reaches upper halfword, low reaches lower
// RULE_08 - swap register all ones swaps the halfword selection
// RULE_09 - network side data order never depends on halfword setting
// RULE_10 - 32-bit counter from zero, steps each 25 MHz cycle, wraps
// RULE_11 - first halfword read latches whole count for the second read
// RULE_12 - counter reaches zero within 160 ns of reset
// RULE_13 - counter runs in every power state
// RULE_14 - each dropped frame adds one to 32-bit drop counter
// RULE_15 - any read of drop counter clears it after returning value; the code clears it only on the first halfword read of a pair
// RULE_16 - event when drop counter steps from 7FFFFFFF to 80000000
// RULE_17 - pending bit write starts mac access, self-clears when done
// RULE_18 - read data valid in data register when pending clears
// RULE_19 - host leaves command and data alone while pending
// RULE_20 - direction bit: one reads mac register, zero writes
// RULE_21 - 8-bit address field picks mac register, resets zero
// RULE_22 - 32-bit data register holds write or read value, resets zero
// RULE_23 - timer counts down from preload, reloads and flags on passing zero
// RULE_24 - host loads data before setting pending for a write
module mscb_csr_block #(
  parameter TMR_STEP_CYC = `MSCB_TMR_STEP_CYC
) (
  input  wire        I_REF_CLK,
  input  wire        I_RST_B,
  input  wire        I_CE,
  input  wire [7:1]  I_ADDR,
  input  wire        I_RD,
  input  wire        I_WR,
  input  wire [15:0] I_WDATA,
  output reg  [15:0] O_RDATA,
  output reg         O_RVALID,
  input  wire        I_EE_DO,
  input  wire        I_EE_DOE,
  input  wire        I_EE_CLK,
  input  wire        I_TX_EN,
  input  wire        I_RX_DV,
  input  wire        I_TX_CLK,
  input  wire        I_RX_CLK,
  input  wire        I_EE_DATA_PIN,
  output reg         O_EE_DATA_PIN,
  output reg         O_EE_DATA_PIN_OE,
  output reg         O_EE_CLK_PIN,
  output reg         O_EE_CLK_PIN_OE,
  output reg         O_EE_DI,
  input  wire        I_FRAME_DROP,
  output reg         O_TIMER_EVT,
  output reg         O_DROP_HALF_EVT,
  output reg         O_MAC_REQ,
  output reg         O_MAC_RNW,
  output reg  [7:0]  O_MAC_ADDR,
  output reg  [31:0] O_MAC_WDATA,
  input  wire        I_MAC_ACK,
  input  wire [31:0] I_MAC_RDATA
);

  localparam [15:0] TICK_DIV_M1 = `MSCB_TICK_DIV - 1;
  localparam [31:0] STEP_M1     = TMR_STEP_CYC - 1;

  // register state
  reg  [2:0]  pin_fn;
  reg         general_output_three;
  reg         general_output_four;
  reg         tmr_run;
  reg  [15:0] tmr_load;
  reg  [15:0] tmr_cnt;
  reg  [31:0] tmr_pre;
  reg  [31:0] hword;
  reg  [15:0] tick_div;
  reg  [31:0] tick_cnt;
  reg  [31:0] tick_snap;
  reg         tick_held;
  reg  [31:0] drop_cnt;
  reg  [31:0] drop_snap;
  reg         drop_held;
  reg         pend;
  reg         rnw;
  reg  [7:0]  mac_addr;
  reg  [31:0] mac_data;

  // halfword lane select and decode
  wire        swapped = (hword == `MSCB_SWAP_KEY);             // RULE_08
  wire        upper   = I_ADDR[1] ^ swapped;                   // RULE_07
  wire [7:0]  off     = {I_ADDR[7:2], 2'b00};
  wire        rd      = I_CE & I_RD;
  wire        wr      = I_CE & I_WR;
  wire        wr_lo   = wr & ~upper;
  wire        wr_hi   = wr & upper;

  reg         sel_pin;
  reg         sel_tcf;
  reg         sel_tcn;
  reg         sel_hw;
  reg         sel_tick;
  reg         sel_drop;
  reg         sel_cmd;
  reg         sel_dat;

  // address decode, one register per aligned word
  always @* begin
    sel_pin  = 1'b0;
    sel_tcf  = 1'b0;
    sel_tcn  = 1'b0;
    sel_hw   = 1'b0;
    sel_tick = 1'b0;
    sel_drop = 1'b0;
    sel_cmd  = 1'b0;
    sel_dat  = 1'b0;
    if (off == `MSCB_OFF_PINCFG) begin
      sel_pin = 1'b1;
    end else if (off == `MSCB_OFF_TMRCFG) begin
      sel_tcf = 1'b1;
    end else if (off == `MSCB_OFF_TMRCNT) begin
      sel_tcn = 1'b1;
    end else if (off == `MSCB_OFF_HWORD) begin
      sel_hw = 1'b1;
    end else if (off == `MSCB_OFF_TICK) begin
      sel_tick = 1'b1;
    end else if (off == `MSCB_OFF_DROP) begin
      sel_drop = 1'b1;
    end else if (off == `MSCB_OFF_MACCMD) begin
      sel_cmd = 1'b1;
    end else if (off == `MSCB_OFF_MACDAT) begin
      sel_dat = 1'b1;
    end
  end

  // full-word views for the read mux
  wire [31:0] pin_word = {9'h000, pin_fn, 15'h0000, general_output_four, general_output_three, 3'h0};
  wire [31:0] tcf_word = {2'h0, tmr_run, 13'h0000, tmr_load};
  wire [31:0] cmd_word = {pend, rnw, 22'h000000, mac_addr};
  wire [31:0] tick_src = tick_held ? tick_snap : tick_cnt;
  wire [31:0] drop_src = drop_held ? drop_snap : drop_cnt;

  reg  [31:0] rd_word;

  // read word select; unmapped offsets read zero
  always @* begin
    rd_word = 32'h00000000;
    if (sel_pin) begin
      rd_word = pin_word;
    end else if (sel_tcf) begin
      rd_word = tcf_word;
    end else if (sel_tcn) begin
      rd_word = {16'h0000, tmr_cnt};                           // RULE_06
    end else if (sel_hw) begin
      rd_word = hword;
    end else if (sel_tick) begin
      rd_word = tick_src;                                      // RULE_11
    end else if (sel_drop) begin
      rd_word = drop_src;
    end else if (sel_cmd) begin
      rd_word = cmd_word;
    end else if (sel_dat) begin
      rd_word = mac_data;
    end
  end

  // host read port, data one cycle after the strobe
  always @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_RDATA  <= 16'h0000;
      O_RVALID <= 1'b0;
    end else if (I_CE) begin
      O_RVALID <= I_RD;
      if (I_RD) begin
        O_RDATA <= upper ? rd_word[31:16] : rd_word[15:0];
      end
    end
  end

  // pin function and general output bits
  always @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pin_fn <= `MSCB_FN_EEPROM;
      general_output_three   <= 1'b0;
      general_output_four   <= 1'b0;
    end else if (wr_hi & sel_pin) begin
      pin_fn <= I_WDATA[`MSCB_PINFN_MSB:`MSCB_PINFN_LSB];
    end else if (wr_lo & sel_pin) begin
      general_output_three <= I_WDATA[`MSCB_GENERAL_OUTPUT_THREE_BIT];
      general_output_four <= I_WDATA[`MSCB_GENERAL_OUTPUT_FOUR_BIT];
    end
  end

  reg next_dpin;
  reg next_doe;
  reg next_cpin;
  reg next_coe;

  // pin routing; reserved codes leave both pins undriven
  always @* begin
    next_dpin = 1'b0;
    next_doe  = 1'b0;
    next_cpin = 1'b0;
    next_coe  = 1'b0;
    case (pin_fn)
      `MSCB_FN_EEPROM: begin
        next_dpin = I_EE_DO;                                   // RULE_01
        next_doe  = I_EE_DOE;
        next_cpin = I_EE_CLK;
        next_coe  = 1'b1;
      end
      `MSCB_FN_GPO_GPO: begin
        next_dpin = general_output_three;                                      // RULE_01
        next_doe  = 1'b1;
        next_cpin = general_output_four;
        next_coe  = 1'b1;
      end
      `MSCB_FN_GPO_RXDV: begin
        next_dpin = general_output_three;                                      // RULE_01
        next_doe  = 1'b1;
        next_cpin = I_RX_DV;
        next_coe  = 1'b1;
      end
      `MSCB_FN_TXEN_GPO: begin
        next_dpin = I_TX_EN;                                   // RULE_01
        next_doe  = 1'b1;
        next_cpin = general_output_four;
        next_coe  = 1'b1;
      end
      `MSCB_FN_TXEN_RXDV: begin
        next_dpin = I_TX_EN;                                   // RULE_01
        next_doe  = 1'b1;
        next_cpin = I_RX_DV;
        next_coe  = 1'b1;
      end
      `MSCB_FN_CLKS: begin
        next_dpin = I_TX_CLK;                                  // RULE_01
        next_doe  = 1'b1;
        next_cpin = I_RX_CLK;
        next_coe  = 1'b1;
      end
      default: begin
        next_doe = 1'b0;
      end
    endcase
  end

  // pin outputs registered: one cycle of lag on forwarded signals
  always @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_EE_DATA_PIN    <= 1'b0;
      O_EE_DATA_PIN_OE <= 1'b0;
      O_EE_CLK_PIN     <= 1'b0;
      O_EE_CLK_PIN_OE  <= 1'b0;
      O_EE_DI          <= 1'b0;
    end else if (I_CE) begin
      O_EE_DATA_PIN    <= next_dpin;
      O_EE_DATA_PIN_OE <= next_doe;
      O_EE_CLK_PIN     <= next_cpin;
      O_EE_CLK_PIN_OE  <= next_coe;
      O_EE_DI          <= I_EE_DATA_PIN;
    end
  end

  wire run_wr   = wr_hi & sel_tcf;
  wire run_fall = run_wr & tmr_run & ~I_WDATA[`MSCB_TMR_RUN_BIT];
  wire step     = tmr_run & (tmr_pre == STEP_M1);

  // timer configuration: run bit and preload
  always @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tmr_run  <= 1'b0;
      tmr_load <= `MSCB_TMR_RST;                               // RULE_04
    end else if (I_CE) begin
      if (run_wr) begin
        tmr_run <= I_WDATA[`MSCB_TMR_RUN_BIT];                 // RULE_02
      end
      if (run_fall) begin
        tmr_load <= `MSCB_TMR_RST;                             // RULE_03
      end else if (wr_lo & sel_tcf) begin
        tmr_load <= I_WDATA;
      end
    end
  end

  // timer: prescaled down count, reload and event on passing zero
  always @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tmr_pre     <= 32'h00000000;
      tmr_cnt     <= `MSCB_TMR_RST;                            // RULE_06
      O_TIMER_EVT <= 1'b0;
    end else if (I_CE) begin
      O_TIMER_EVT <= 1'b0;
      if (!tmr_run) begin
        tmr_pre <= 32'h00000000;
        tmr_cnt <= tmr_load;                                   // RULE_04
      end else if (step) begin
        tmr_pre <= 32'h00000000;
        if (tmr_cnt == 16'h0000) begin
          tmr_cnt     <= tmr_load;                             // RULE_23
          O_TIMER_EVT <= 1'b1;                                 // RULE_05
        end else begin
          tmr_cnt <= tmr_cnt - 16'h0001;                       // RULE_23
        end
      end else begin
        tmr_pre <= tmr_pre + 32'h00000001;
      end
    end
  end

  // halfword order register, written a half at a time
  always @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      hword <= 32'h00000000;
    end else if (wr_hi & sel_hw) begin
      hword[31:16] <= I_WDATA;
    end else if (wr_lo & sel_hw) begin
      hword[15:0] <= I_WDATA;
    end
  end
  // swap only steers host lanes; no network-side path passes here RULE_09

  // free-running count: async reset gives zero at once, well under 160 ns
  // no power-state input gates it, so it runs in every state
  always @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tick_div <= 16'h0000;
      tick_cnt <= 32'h00000000;                                // RULE_12
    end else if (I_CE) begin
      if (tick_div == TICK_DIV_M1) begin
        tick_div <= 16'h0000;
        tick_cnt <= tick_cnt + 32'h00000001;                   // RULE_10 RULE_13
      end else begin
        tick_div <= tick_div + 16'h0001;
      end
    end
  end

  // snapshot on first halfword read, released by the second
  always @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tick_snap <= 32'h00000000;
      tick_held <= 1'b0;
    end else if (rd & sel_tick) begin
      tick_held <= ~tick_held;                                 // RULE_11
      if (!tick_held) begin
        tick_snap <= tick_cnt;                                 // RULE_11
      end
    end
  end

  wire drop_clr = rd & sel_drop & ~drop_held;

  // drop counter: a drop in the clearing cycle survives as one
  always @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      drop_cnt        <= 32'h00000000;
      drop_snap       <= 32'h00000000;
      drop_held       <= 1'b0;
      O_DROP_HALF_EVT <= 1'b0;
    end else if (I_CE) begin
      O_DROP_HALF_EVT <= I_FRAME_DROP & (drop_cnt == 32'h7FFFFFFF) & ~drop_clr; // RULE_16
      if (rd & sel_drop) begin
        drop_held <= ~drop_held;
        if (!drop_held) begin
          drop_snap <= drop_cnt;                               // RULE_15
        end
      end
      if (drop_clr) begin
        drop_cnt <= {31'h00000000, I_FRAME_DROP};              // RULE_15 RULE_14
      end else if (I_FRAME_DROP) begin
        drop_cnt <= drop_cnt + 32'h00000001;                   // RULE_14
      end
    end
  end

  // indirect mac access: writes while pending are ignored
  always @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pend     <= 1'b0;
      rnw      <= 1'b0;
      mac_addr <= 8'h00;                                       // RULE_21
      mac_data <= 32'h00000000;                                // RULE_22
    end else if (I_CE) begin
      if (pend) begin
        if (I_MAC_ACK) begin
          pend <= 1'b0;                                        // RULE_17
          if (rnw) begin
            mac_data <= I_MAC_RDATA;                           // RULE_18
          end
        end
      end else if (wr_hi & sel_cmd) begin
        pend <= I_WDATA[`MSCB_CMD_PEND_BIT];                   // RULE_17
        rnw  <= I_WDATA[`MSCB_CMD_RNW_BIT];                    // RULE_20
      end else if (wr_lo & sel_cmd) begin
        mac_addr <= I_WDATA[7:0];                              // RULE_21
      end else if (wr_hi & sel_dat) begin
        mac_data[31:16] <= I_WDATA;                            // RULE_22 RULE_24
      end else if (wr_lo & sel_dat) begin
        mac_data[15:0] <= I_WDATA;                             // RULE_22
      end
    end
  end

  // request side toward the mac registers, held while pending
  always @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_MAC_REQ   <= 1'b0;
      O_MAC_RNW   <= 1'b0;
      O_MAC_ADDR  <= 8'h00;
      O_MAC_WDATA <= 32'h00000000;
    end else if (I_CE) begin
      O_MAC_REQ   <= pend & ~I_MAC_ACK & ~O_MAC_REQ | O_MAC_REQ & ~I_MAC_ACK; // RULE_17
      O_MAC_RNW   <= rnw;                                      // RULE_20
      O_MAC_ADDR  <= mac_addr;
      O_MAC_WDATA <= mac_data;                                 // RULE_19
    end
  end

endmodule
`default_nettype wire

// File: verification/mscb_csr_block_properties.sv
/*
  port checker for the csr block: host read timing, mac handshake, timer events.
  assumes one clock domain and a timer step of at least 4 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module mscb_csr_block_properties #(
  parameter TMR_STEP_CYC = 4
) (
  input wire logic        I_REF_CLK,
  input wire logic        I_RST_B,
  input wire logic        I_CE,
  input wire logic [7:1]  I_ADDR,
  input wire logic        I_RD,
  input wire logic        I_WR,
  input wire logic [15:0] O_RDATA,
  input wire logic        O_RVALID,
  input wire logic        O_TIMER_EVT,
  input wire logic        O_DROP_HALF_EVT,
  input wire logic        I_FRAME_DROP,
  input wire logic        O_MAC_REQ,
  input wire logic        O_MAC_RNW,
  input wire logic [7:0]  O_MAC_ADDR,
  input wire logic [31:0] O_MAC_WDATA,
  input wire logic        I_MAC_ACK
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_B);

  // host reads answer one cycle later and data holds between reads
  a_read_answered: assert property (I_CE && I_RD |=> O_RVALID)
    else $error("read not answered next cycle");
  a_no_stray_valid: assert property (!(I_CE && I_RD) |=> !O_RVALID)
    else $error("read valid without a read");
  a_rdata_holds: assert property (!(I_CE && I_RD) |=> $stable(O_RDATA))
    else $error("read data moved without a read");

  // indirect access: started only by a command write, held until acknowledged
  a_req_from_cmd: assert property ($rose(O_MAC_REQ) |-> $past(I_WR && I_ADDR[7:2] == 6'h29, 2))
    else $error("mac request without command write");
  a_req_holds: assert property (O_MAC_REQ && !I_MAC_ACK && !$past(I_MAC_ACK) |=> O_MAC_REQ)
    else $error("mac request dropped before ack");
  a_req_ends: assert property (O_MAC_REQ && I_MAC_ACK |-> ##[1:2] !O_MAC_REQ)
    else $error("mac request not released after ack");
  a_fields_stable: assert property (O_MAC_REQ && $past(O_MAC_REQ) && !$past(I_MAC_ACK)
    |-> $stable({O_MAC_RNW, O_MAC_ADDR, O_MAC_WDATA}))
    else $error("mac command changed while pending");

  // one event per step at most, steps are four cycles in simulation
  a_timer_spacing: assert property (O_TIMER_EVT |=> !O_TIMER_EVT [*3])
    else $error("timer events too close");

  // halfway event only follows a dropped frame, and never twice running
  a_half_evt_cause: assert property (O_DROP_HALF_EVT |-> $past(I_FRAME_DROP) && $past(I_CE))
    else $error("halfway event without a dropped frame");
  a_half_evt_pulse: assert property (O_DROP_HALF_EVT |=> !O_DROP_HALF_EVT)
    else $error("halfway event longer than one cycle");
endmodule

bind mscb_csr_block mscb_csr_block_properties #(.TMR_STEP_CYC(TMR_STEP_CYC)) u_props (
  .I_REF_CLK(I_REF_CLK), .I_RST_B(I_RST_B), .I_CE(I_CE), .I_ADDR(I_ADDR), .I_RD(I_RD),
  .I_WR(I_WR), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .O_TIMER_EVT(O_TIMER_EVT),
  .O_DROP_HALF_EVT(O_DROP_HALF_EVT), .I_FRAME_DROP(I_FRAME_DROP),
  .O_MAC_REQ(O_MAC_REQ), .O_MAC_RNW(O_MAC_RNW), .O_MAC_ADDR(O_MAC_ADDR),
  .O_MAC_WDATA(O_MAC_WDATA), .I_MAC_ACK(I_MAC_ACK));
`default_nettype wire

// File: verification/mscb_mac_model.sv
/*
  behavioural mac register space answering the indirect port.
  assumes a level request held until one-cycle ack; delay set by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module mscb_mac_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic [3:0]  i_delay,
  input  wire logic        i_req,
  input  wire logic        i_rnw,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  output var  logic        o_ack,
  output var  logic [31:0] o_rdata
);
  logic [31:0] mem [256];
  logic [1:0]  st;
  logic [3:0]  cnt;

  // wait, answer once, then wait for the request to drop
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ack <= 1'b0;
      o_rdata <= 32'h0;
      st <= 2'h0;
      cnt <= 4'h0;
    end else begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata; // bus not valid outside ack, keep it moving
      case (st)
        2'h0: if (i_req) begin
          cnt <= i_delay;
          st <= 2'h1;
        end
        2'h1: if (cnt != 4'h0) begin
          cnt <= cnt - 4'h1;
        end else begin
          o_ack <= 1'b1;
          st <= 2'h2;
          if (i_rnw) o_rdata <= mem[i_addr];
          else mem[i_addr] <= i_wdata;
        end
        default: if (!i_req) st <= 2'h0;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: verification/mscb_csr_block_tb.sv
/*
  self-checking bench for the csr block: registers, halfword order, timer,
  counters, pin routing and the indirect mac port.
  assumes the mac model beside it and a short timer step.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin checks_done++; if ((act) !== (exp)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, (act), (exp)); end end
module mscb_csr_block_tb;
  logic        clk, rst_b, ce, rd, wr, drop, ack, rvalid, evt, half_evt, req, rnw;
  logic        dpin, doe, cpin, coe, di;
  logic [6:0]  addr;
  logic [15:0] wdata, rdata, v;
  logic [7:0]  pins, maddr, a8;
  logic [31:0] mwdata, mrdata, e, d32;
  logic [3:0]  dly, e4, m;
  logic [1:0]  g;
  logic [31:0] expq[$];
  int          miscompares, checks_done, cyc, evts, t0, n;
  logic [23:0] rst_tab [12] = '{24'h8CFFFF, 24'h8E0000, 24'h90FFFF, 24'h920000, 24'h980000, 24'h9A0000,
                                24'hA00000, 24'hA20000, 24'hA40000, 24'hA60000, 24'hA80000, 24'hAA0000};

  mscb_csr_block #(.TMR_STEP_CYC(4)) uut (
    .I_REF_CLK(clk), .I_RST_B(rst_b), .I_CE(ce), .I_ADDR(addr), .I_RD(rd), .I_WR(wr),
    .I_WDATA(wdata), .O_RDATA(rdata), .O_RVALID(rvalid), .I_EE_DO(pins[0]), .I_EE_DOE(pins[1]),
    .I_EE_CLK(pins[2]), .I_TX_EN(pins[3]), .I_RX_DV(pins[4]), .I_TX_CLK(pins[5]), .I_RX_CLK(pins[6]),
    .I_EE_DATA_PIN(pins[7]), .O_EE_DATA_PIN(dpin), .O_EE_DATA_PIN_OE(doe), .O_EE_CLK_PIN(cpin),
    .O_EE_CLK_PIN_OE(coe), .O_EE_DI(di), .I_FRAME_DROP(drop), .O_TIMER_EVT(evt),
    .O_DROP_HALF_EVT(half_evt), .O_MAC_REQ(req), .O_MAC_RNW(rnw), .O_MAC_ADDR(maddr),
    .O_MAC_WDATA(mwdata), .I_MAC_ACK(ack), .I_MAC_RDATA(mrdata));

  mscb_mac_model u_mac (
    .i_clk(clk), .i_rst_b(rst_b), .i_delay(dly), .i_req(req), .i_rnw(rnw), .i_addr(maddr),
    .i_wdata(mwdata), .o_ack(ack), .o_rdata(mrdata));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // cycle count, event tally and hang guard
  always @(posedge clk) begin
    cyc++;
    if (evt) evts++;
    if (cyc > 20000) begin
      miscompares++;
      end_sim;
    end
  end

  // oldest note against each returned halfword; upper half of a note is a tolerance
  always @(posedge clk) begin
    if (rvalid) begin
      e = expq.pop_front();
      `CHK(((rdata - e[15:0]) <= e[31:16]) ? e[15:0] : rdata, e[15:0])
    end
  end

  task automatic end_sim;
    if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a[7:1];
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd16(input logic [7:0] a, input logic [15:0] x, input logic [15:0] tol = 16'h0);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a[7:1];
    expq.push_back({tol, x});
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // wait for the indirect request to rise and fall, bounded
  task automatic mac_wait;
    int i;
    i = 0;
    while (!req && i < 50) begin @(posedge clk); i++; end
    while (req && i < 50) begin @(posedge clk); i++; end
    `CHK(i < 50, 1'b1)
    @(posedge clk);
  endtask

  initial begin
    rst_b = 1'b0; ce = 1'b1; rd = 1'b0; wr = 1'b0; drop = 1'b0;
    addr = 7'h0; wdata = 16'h0; pins = 8'h0; dly = 4'h0;
    void'($urandom(54));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    // free-running count just after release, then reset values of the map except the pin register
    rd16(8'h9C, 16'h0, 16'h5);
    rd16(8'h9E, 16'h0);
    for (int k = 0; k < 12; k++) rd16(rst_tab[k][23:16], rst_tab[k][15:0]);
    rd16(8'hB0, 16'h0);
    // halfword order: normal, swapped, then back through the upper half
    v = $urandom;
    wr16(8'h8C, v);
    rd16(8'h8C, v);
    wr16(8'h98, 16'hFFFF);
    wr16(8'h9A, 16'hFFFF);
    rd16(8'h8E, v);
    rd16(8'h8C, 16'h0);
    wr16(8'h98, 16'h0);
    rd16(8'h98, 16'hFFFF);
    rd16(8'h9A, 16'h0);
    // timer: read-only count, preload, run, halt
    wr16(8'h90, 16'h1234);
    wr16(8'h8C, 16'h0002);
    rd16(8'h90, 16'h0002);
    evts = 0;
    wr16(8'h8E, 16'h2000);
    repeat (120) @(posedge clk);
    `CHK(evts >= 9 && evts <= 11, 1'b1)
    wr16(8'h8E, 16'h0000);
    rd16(8'h8C, 16'hFFFF);
    rd16(8'h90, 16'hFFFF);
    evts = 0;
    repeat (60) @(posedge clk);
    `CHK(evts, 0)
    // free-running count: the later half comes from the first read's snapshot
    t0 = (cyc - 4) / 10;
    rd16(8'h9E, 16'h0);
    repeat (200) @(posedge clk);
    rd16(8'h9C, 16'(t0 - 4), 16'h6);
    t0 = (cyc - 4) / 10;
    rd16(8'h9C, 16'(t0 - 4), 16'h6);
    // dropped frames, cleared by reading
    n = 1 + $urandom % 20;
    repeat (n) begin
      @(posedge clk);
      drop <= 1'b1;
      @(posedge clk);
      drop <= 1'b0;
    end
    `CHK(half_evt, 1'b0)
    rd16(8'hA0, n[15:0]);
    rd16(8'hA2, 16'h0);
    rd16(8'hA0, 16'h0);
    // every pin function code with random pin sources
    for (int f = 0; f < 8; f++) begin
      g = $urandom;
      wr16(8'h88, {11'h0, g, 3'h0});
      wr16(8'h8A, {9'h0, f[2:0], 4'h0});
      pins <= $urandom;
      repeat (3) @(posedge clk);
      case (f)
        0: e4 = {pins[0], pins[1], pins[2], 1'b1};
        1: e4 = {g[0], 1'b1, g[1], 1'b1};
        3: e4 = {g[0], 1'b1, pins[4], 1'b1};
        5: e4 = {pins[3], 1'b1, g[1], 1'b1};
        6: e4 = {pins[3], 1'b1, pins[4], 1'b1};
        7: e4 = {pins[5], 1'b1, pins[6], 1'b1};
        default: e4 = 4'h0;
      endcase
      m = (f == 2 || f == 4) ? 4'b0101 : 4'hF; // reserved codes: only enables matter
      `CHK({dpin, doe, cpin, coe} & m, e4 & m)
      `CHK(di, pins[7])
    end
    // indirect write then read back, prompt and slow mac, a refused write in each pass
    for (int k = 0; k < 2; k++) begin
      a8 = $urandom;
      d32 = $urandom;
      dly <= k ? 4'h7 : 4'h0;
      wr16(8'hA8, d32[15:0]);
      wr16(8'hAA, d32[31:16]);
      wr16(8'hA4, {8'h0, a8});
      wr16(8'hA6, 16'h8000);
      wr16(8'hA8, ~d32[15:0]); // refused while pending
      mac_wait;
      wr16(8'hA8, 16'h0);
      wr16(8'hAA, 16'h0);
      wr16(8'hA6, 16'hC000);
      mac_wait;
      rd16(8'hA6, 16'h4000);
      rd16(8'hA4, {8'h0, a8});
      rd16(8'hA8, d32[15:0]);
      rd16(8'hAA, d32[31:16]);
    end
    repeat (5) @(posedge clk);
    `CHK(expq.size(), 0)
    end_sim;
  end
endmodule
`default_nettype wire
